//--- design/ssv_map.vh
// Constants of the serial stereo volume control logic.
`ifndef SSV_MAP_VH
`define SSV_MAP_VH
// Serial word length and per-channel code width.
`define SSV_WORD_BITS 16
`define SSV_CODE_BITS 8
// Field positions inside the latched word (first byte in is the right channel).
`define SSV_RIGHT_MSB 15
`define SSV_RIGHT_LSB 8
`define SSV_LEFT_MSB 7
`define SSV_LEFT_LSB 0
// Reset value of shift and volume registers.
`define SSV_WORD_RESET 16'h0000
// Special codes.
`define SSV_CODE_MUTE 8'h00
`define SSV_CODE_UNITY 8'hC0
// Zero crossings needed before a change is applied.
`define SSV_ZC_NEEDED 2'h2
// Clock rate in kHz and times in microseconds.
`define SSV_CLK_KHZ 40000
`define SSV_TIMEOUT_US 18000
`define SSV_POR_US 100
`define SSV_TIMEOUT_CYC ((`SSV_TIMEOUT_US * `SSV_CLK_KHZ) / 1000)
`define SSV_POR_CYC ((`SSV_POR_US * `SSV_CLK_KHZ) / 1000)
`endif

//--- design/ssv_volume_ctrl.v
// Digital control logic of the serial stereo volume control.
`timescale 1ns/1ps
`include "ssv_map.vh"
// Function
// - Sample serial_in MSB first on rising shift clock.
// - First byte right gain, second byte left.
// - Select rising edge copies shift register to volume.
// - Shift out old data on falling clock.
// - Shift path delays data exactly sixteen clocks.
// - All chained devices load on select rise.
// - serial_out high impedance while select high.
// - Codes map to half-dB steps, C0 unity.
// - Zero code gives software mute.
// - Apply level after two zero crossings.
// - Apply anyway after 18 ms timeout.
// - Enable gates volume-change detection and timeout together; hardware mute ignores it.
// - Crossings detected separately per channel.
// - Hardware mute grounds both outputs.
// - Hardware mute at crossing or 18 ms.
// - Hardware mute starts offset calibration.
// - Enable high activates crossing detection for volume changes.
// - Mute power-up clears shift and volume registers.
// - Ignore writes during power-on settling.
// - Mute lasts long enough for calibration.
module ssv_volume_ctrl #(
    parameter TIMEOUT_CYC = `SSV_TIMEOUT_CYC,
    parameter POR_CYC = `SSV_POR_CYC
) (
    input wire clock_in,
    input wire rstn_in,
    input wire shift_clock_in,
    input wire serial_in,
    input wire select_n_in,
    input wire mute_n_in,
    input wire zero_cross_enable_in,
    input wire left_zero_cross_in,
    input wire right_zero_cross_in,
    output reg serial_out,
    output wire serial_out_oe_out,
    output reg [7:0] left_code_out,
    output reg [7:0] right_code_out,
    output reg left_soft_mute_out,
    output reg right_soft_mute_out,
    output reg [8:0] left_level_half_db_out,
    output reg [8:0] right_level_half_db_out,
    output reg hard_mute_out,
    output reg calibrate_start_out,
    output wire ready_out
);

// ----------------------------------------
// Helpers
// ----------------------------------------

// Signed level in half-dB steps relative to unity; a nine-bit result keeps -191..+63.
function [8:0] code_to_level;
    input [7:0] code;
    begin
        code_to_level = {1'b0, code} - {1'b0, `SSV_CODE_UNITY};
    end
endfunction

// ----------------------------------------
// Input synchronisers
// ----------------------------------------

// Three-stage pipes; stage 0 feeds only stage 1, stages 1 and 2 are compared except on serial_in, whose stage 2 is used directly.
reg [2:0] sck_sync_reg;
reg [2:0] sel_sync_reg;
reg [2:0] sdi_sync_reg;
reg [2:0] mute_sync_reg;
reg [2:0] zce_sync_reg;
reg [2:0] lzc_sync_reg;
reg [2:0] rzc_sync_reg;
// Filtered levels, updated only when the two late stages agree.
reg sck_reg;
reg sel_reg;
reg mute_reg;
reg zce_reg;
reg lzc_reg;
reg rzc_reg;

// Shift all pins through their synchronisers.
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        sck_sync_reg <= 3'h0;
        sel_sync_reg <= 3'h7;
        sdi_sync_reg <= 3'h0;
        mute_sync_reg <= 3'h7;
        zce_sync_reg <= 3'h0;
        lzc_sync_reg <= 3'h0;
        rzc_sync_reg <= 3'h0;
    end else begin
        sck_sync_reg <= {sck_sync_reg[1:0], shift_clock_in};
        sel_sync_reg <= {sel_sync_reg[1:0], select_n_in};
        sdi_sync_reg <= {sdi_sync_reg[1:0], serial_in};
        mute_sync_reg <= {mute_sync_reg[1:0], mute_n_in};
        zce_sync_reg <= {zce_sync_reg[1:0], zero_cross_enable_in};
        lzc_sync_reg <= {lzc_sync_reg[1:0], left_zero_cross_in};
        rzc_sync_reg <= {rzc_sync_reg[1:0], right_zero_cross_in};
    end
end

// Accept a level change once the last two stages agree, rejecting single-cycle glitches.
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        sck_reg <= 1'b0;
        sel_reg <= 1'b1;
        mute_reg <= 1'b1;
        zce_reg <= 1'b0;
        lzc_reg <= 1'b0;
        rzc_reg <= 1'b0;
    end else begin
        if (sck_sync_reg[1] == sck_sync_reg[2]) begin
            sck_reg <= sck_sync_reg[2];
        end
        if (sel_sync_reg[1] == sel_sync_reg[2]) begin
            sel_reg <= sel_sync_reg[2];
        end
        if (mute_sync_reg[1] == mute_sync_reg[2]) begin
            mute_reg <= mute_sync_reg[2];
        end
        if (zce_sync_reg[1] == zce_sync_reg[2]) begin
            zce_reg <= zce_sync_reg[2];
        end
        if (lzc_sync_reg[1] == lzc_sync_reg[2]) begin
            lzc_reg <= lzc_sync_reg[2];
        end
        if (rzc_sync_reg[1] == rzc_sync_reg[2]) begin
            rzc_reg <= rzc_sync_reg[2];
        end
    end
end

// Edge events derived from the filtered levels.
wire sck_rise = (sck_sync_reg[1] == sck_sync_reg[2]) && sck_sync_reg[2] && !sck_reg;
wire sck_fall = (sck_sync_reg[1] == sck_sync_reg[2]) && !sck_sync_reg[2] && sck_reg;
wire sel_rise = (sel_sync_reg[1] == sel_sync_reg[2]) && sel_sync_reg[2] && !sel_reg;
wire mute_fall = (mute_sync_reg[1] == mute_sync_reg[2]) && !mute_sync_reg[2] && mute_reg;
// A crossing is any change of the comparator level; each channel has its own.
wire lzc_evt = (lzc_sync_reg[1] == lzc_sync_reg[2]) && (lzc_sync_reg[2] != lzc_reg);
wire rzc_evt = (rzc_sync_reg[1] == rzc_sync_reg[2]) && (rzc_sync_reg[2] != rzc_reg);

// ----------------------------------------
// Power-on settling and hardware mute
// ----------------------------------------

reg [31:0] por_cnt_reg;
reg [15:0] shift_reg;
reg [15:0] volume_reg;

assign ready_out = (por_cnt_reg == 32'h0000_0000);

// Settling counter restarts whenever a mute power-up sequence begins.
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        por_cnt_reg <= POR_CYC;
        calibrate_start_out <= 1'b0;
    end else begin
        calibrate_start_out <= mute_fall;
        if (mute_fall) begin
            por_cnt_reg <= POR_CYC;
        end else if (!ready_out) begin
            por_cnt_reg <= por_cnt_reg - 32'h0000_0001;
        end
    end
end

// ----------------------------------------
// Serial shift path
// ----------------------------------------

// The port is live only while selected and past settling; the mute sequence clears it.
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        shift_reg <= `SSV_WORD_RESET;
        serial_out <= 1'b0;
    end else if (mute_fall) begin
        shift_reg <= `SSV_WORD_RESET;
        serial_out <= 1'b0;
    end else if (ready_out && !sel_reg) begin
        if (sck_rise) begin
            shift_reg <= {shift_reg[14:0], sdi_sync_reg[2]};
        end
        if (sck_fall) begin
            serial_out <= shift_reg[15];
        end
    end
end

assign serial_out_oe_out = !sel_reg;

// ----------------------------------------
// Volume register and per-channel apply
// ----------------------------------------

reg [1:0] left_zc_cnt_reg;
reg [1:0] right_zc_cnt_reg;
reg left_pend_reg;
reg right_pend_reg;
reg [31:0] timer_reg;
reg mute_pend_reg;
reg [31:0] mute_timer_reg;

always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        volume_reg <= `SSV_WORD_RESET;
    end else if (mute_fall) begin
        volume_reg <= `SSV_WORD_RESET;
    end else if (sel_rise && ready_out) begin
        volume_reg <= shift_reg;
    end
end

wire load_evt = sel_rise && ready_out && !mute_fall;
wire timed_out = (timer_reg == 32'h0000_0001);
wire zc_on = zce_reg;

// Apply the latched codes after two crossings per channel, the timeout, or at once.
always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        left_code_out <= `SSV_CODE_MUTE;
        right_code_out <= `SSV_CODE_MUTE;
        left_pend_reg <= 1'b0;
        right_pend_reg <= 1'b0;
        left_zc_cnt_reg <= 2'h0;
        right_zc_cnt_reg <= 2'h0;
        timer_reg <= 32'h0000_0000;
    end else if (mute_fall) begin
        left_code_out <= `SSV_CODE_MUTE;
        right_code_out <= `SSV_CODE_MUTE;
        left_pend_reg <= 1'b0;
        right_pend_reg <= 1'b0;
        timer_reg <= 32'h0000_0000;
    end else if (load_evt) begin
        left_zc_cnt_reg <= 2'h0;
        right_zc_cnt_reg <= 2'h0;
        if (!zc_on) begin
            right_code_out <= shift_reg[`SSV_RIGHT_MSB:`SSV_RIGHT_LSB];
            left_code_out <= shift_reg[`SSV_LEFT_MSB:`SSV_LEFT_LSB];
            left_pend_reg <= 1'b0;
            right_pend_reg <= 1'b0;
            timer_reg <= 32'h0000_0000;
        end else begin
            left_pend_reg <= 1'b1;
            right_pend_reg <= 1'b1;
            timer_reg <= TIMEOUT_CYC;
        end
    end else begin
        // Dropping the enable mid-wait applies the pending codes immediately.
        if (timer_reg != 32'h0000_0000) begin
            timer_reg <= timer_reg - 32'h0000_0001;
        end
        if (left_pend_reg && lzc_evt) begin
            left_zc_cnt_reg <= left_zc_cnt_reg + 2'h1;
        end
        if (right_pend_reg && rzc_evt) begin
            right_zc_cnt_reg <= right_zc_cnt_reg + 2'h1;
        end
        if (left_pend_reg && (!zc_on || timed_out || (lzc_evt && left_zc_cnt_reg == `SSV_ZC_NEEDED - 2'h1))) begin
            left_code_out <= volume_reg[`SSV_LEFT_MSB:`SSV_LEFT_LSB];
            left_pend_reg <= 1'b0;
        end
        if (right_pend_reg && (!zc_on || timed_out || (rzc_evt && right_zc_cnt_reg == `SSV_ZC_NEEDED - 2'h1))) begin
            right_code_out <= volume_reg[`SSV_RIGHT_MSB:`SSV_RIGHT_LSB];
            right_pend_reg <= 1'b0;
        end
    end
end

always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        left_soft_mute_out <= 1'b1;
        right_soft_mute_out <= 1'b1;
        left_level_half_db_out <= 9'h000;
        right_level_half_db_out <= 9'h000;
    end else begin
        left_soft_mute_out <= (left_code_out == `SSV_CODE_MUTE);
        right_soft_mute_out <= (right_code_out == `SSV_CODE_MUTE);
        // Muted channels report unity gain, as the amplifier is forced there.
        left_level_half_db_out <= (left_code_out == `SSV_CODE_MUTE) ? 9'h000 : code_to_level(left_code_out);
        right_level_half_db_out <= (right_code_out == `SSV_CODE_MUTE) ? 9'h000 : code_to_level(right_code_out);
    end
end

// ----------------------------------------
// Hardware mute engage
// ----------------------------------------

always @(posedge clock_in or negedge rstn_in) begin
    if (!rstn_in) begin
        hard_mute_out <= 1'b1;
        mute_pend_reg <= 1'b0;
        mute_timer_reg <= 32'h0000_0000;
    end else if (mute_fall) begin
        mute_pend_reg <= 1'b1;
        mute_timer_reg <= TIMEOUT_CYC;
    end else if (mute_reg) begin
        hard_mute_out <= 1'b0;
        mute_pend_reg <= 1'b0;
    end else if (mute_pend_reg) begin
        mute_timer_reg <= mute_timer_reg - 32'h0000_0001;
        if (lzc_evt || rzc_evt || mute_timer_reg == 32'h0000_0001) begin
            hard_mute_out <= 1'b1;
            mute_pend_reg <= 1'b0;
        end
    end
end

endmodule

//--- test/ssv_checker.sv
// Port assertions for the serial volume control.
`timescale 1ns/1ps
module ssv_checker (
    input wire clock_in,
    input wire rstn_in,
    input wire select_n_in,
    input wire mute_n_in,
    input wire serial_out_oe_out,
    input wire [7:0] left_code_out,
    input wire [7:0] right_code_out,
    input wire left_soft_mute_out,
    input wire right_soft_mute_out,
    input wire [8:0] left_level_half_db_out,
    input wire [8:0] right_level_half_db_out,
    input wire calibrate_start_out,
    input wire ready_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rstn_in);
    // Six cycles covers the pin synchroniser.
    sequence s_desel;
        select_n_in [*6];
    endsequence
    sequence s_sel;
        !select_n_in [*6];
    endsequence
    // Derived outputs lag the applied code by one register stage.
    sequence s_lhold;
        $stable(left_code_out) [*3];
    endsequence
    sequence s_rhold;
        $stable(right_code_out) [*3];
    endsequence
    chk_oe_idle: assert property (s_desel |-> !serial_out_oe_out)
        else $error("serial output driven while deselected");
    chk_oe_active: assert property (s_sel ##0 ready_out |-> serial_out_oe_out)
        else $error("serial output not driven while selected");
    chk_soft_left: assert property (s_lhold |-> left_soft_mute_out == (left_code_out == 8'h00))
        else $error("left soft mute disagrees with code");
    chk_soft_right: assert property (s_rhold |-> right_soft_mute_out == (right_code_out == 8'h00))
        else $error("right soft mute disagrees with code");
    chk_level_left: assert property (s_lhold |-> left_level_half_db_out ==
        ((left_code_out == 8'h00) ? 9'h000 : {1'b0, left_code_out} - 9'h0C0))
        else $error("left level disagrees with code");
    chk_level_right: assert property (s_rhold |-> right_level_half_db_out ==
        ((right_code_out == 8'h00) ? 9'h000 : {1'b0, right_code_out} - 9'h0C0))
        else $error("right level disagrees with code");
    chk_cal_pulse: assert property (calibrate_start_out |=> !calibrate_start_out && !mute_n_in)
        else $error("calibration start longer than one cycle");
    chk_unready_codes: assert property (!ready_out |-> left_code_out == 8'h00 && right_code_out == 8'h00)
        else $error("codes changed before settling");
    chk_mute_clear: assert property ($fell(mute_n_in) |-> ##[1:8] (left_code_out == 8'h00 &&
        right_code_out == 8'h00))
        else $error("mute did not clear the codes");
endmodule
bind ssv_volume_ctrl ssv_checker i_chk (.clock_in(clock_in), .rstn_in(rstn_in), .select_n_in(select_n_in),
    .mute_n_in(mute_n_in), .serial_out_oe_out(serial_out_oe_out), .left_code_out(left_code_out),
    .right_code_out(right_code_out), .left_soft_mute_out(left_soft_mute_out),
    .right_soft_mute_out(right_soft_mute_out),
    .left_level_half_db_out(left_level_half_db_out), .right_level_half_db_out(right_level_half_db_out),
    .calibrate_start_out(calibrate_start_out), .ready_out(ready_out));

//--- test/ssv_host.sv
// Host controller model driving the three-wire serial port.
`timescale 1ns/1ps
module ssv_host (
    input wire clock_in,
    input wire echo_in,
    output reg shift_clock_out,
    output reg data_out,
    output reg select_n_out
);
    reg [31:0] rx; // Bits read back from the device, first bit highest.
    integer k;
    initial begin
        shift_clock_out = 1'b0;
        data_out = 1'b0;
        select_n_out = 1'b1;
        rx = 32'h0000_0000;
    end
    // frames MSB first
    // One frame is n pulses of 200 ns; n is 16 per chained device.
    task send(input [31:0] w, input integer n);
        begin
            rx = 32'h0000_0000;
            @(posedge clock_in);
            select_n_out <= 1'b0;
            for (k = n - 1; k >= 0; k = k - 1) begin
                data_out <= w[k];
                repeat (4) @(posedge clock_in);
                shift_clock_out <= 1'b1;
                repeat (3) @(posedge clock_in);
                rx = {rx[30:0], echo_in};
                @(posedge clock_in);
                shift_clock_out <= 1'b0;
            end
            repeat (3) @(posedge clock_in);
            select_n_out <= 1'b1;
            data_out <= 1'b0;
        end
    endtask
endmodule

//--- test/tb.sv
// Self-checking bench of the serial volume control.
`timescale 1ns/1ps
module tb;
    reg clock_in = 1'b0;
    reg rstn_in = 1'b0;
    reg mute_n_in = 1'b1;
    reg zce = 1'b0;
    reg lzc = 1'b0;
    reg rzc = 1'b0;
    wire sck, sdi, csn, sdo, oe, lsm, rsm, hmute, cal, rdy;
    wire [7:0] lcode, rcode;
    wire [8:0] llev, rlev;
    integer n_errors = 0;
    integer n_compared = 0;
    integer seed = 9;
    integer cyc = 0;
    integer i, n;
    reg [15:0] prev = 16'h0000; // Word the device holds, as the model sees it.
    reg [7:0] exp_l = 8'h00;
    reg [7:0] exp_r = 8'h00;
    reg [31:0] w = 32'h0000_0000;
    initial begin
        forever #12.5 clock_in = ~clock_in;
    end
    // Short counts keep the run brief.
    ssv_volume_ctrl #(.TIMEOUT_CYC(200), .POR_CYC(20)) i_dut (.clock_in(clock_in), .rstn_in(rstn_in),
        .shift_clock_in(sck), .serial_in(sdi), .select_n_in(csn), .mute_n_in(mute_n_in),
        .zero_cross_enable_in(zce), .left_zero_cross_in(lzc), .right_zero_cross_in(rzc), .serial_out(sdo),
        .serial_out_oe_out(oe), .left_code_out(lcode), .right_code_out(rcode), .left_soft_mute_out(lsm),
        .right_soft_mute_out(rsm), .left_level_half_db_out(llev), .right_level_half_db_out(rlev),
        .hard_mute_out(hmute), .calibrate_start_out(cal), .ready_out(rdy));
    ssv_host i_host (.clock_in(clock_in), .echo_in(sdo), .shift_clock_out(sck), .data_out(sdi),
        .select_n_out(csn));
    function [8:0] lev(input [7:0] c);
        lev = (c == 8'h00) ? 9'h000 : {1'b0, c} - 9'h0C0;
    endfunction
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("unexpected at %0t: got %h want %h", $time, got, exp);
            end
        end
    endtask
    task check_out;
        begin
            chk(rcode, exp_r);
            chk(lcode, exp_l);
            chk(llev, lev(exp_l));
            chk(rlev, lev(exp_r));
            chk(lsm, exp_l == 8'h00);
            chk(rsm, exp_r == 8'h00);
        end
    endtask
    task wt(input integer c);
        repeat (c) @(posedge clock_in);
    endtask
    task conclude;
        begin
            $display("errors %0d compared %0d", n_errors, n_compared);
            if (n_errors == 0 && n_compared > 0)
                $display("Finished cleanly");
            else
                $display("Finished with errors");
            $finish;
        end
    endtask
    // A hang counts as a mismatch.
    always @(posedge clock_in) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            $display("unexpected at %0t: timeout", $time);
            conclude;
        end
    end
    initial begin
        wt(10);
        rstn_in <= 1'b1;
        wt(30);
        chk(rdy, 1'b1);
        check_out;
        // Boundary codes, then random words; frame 4 is a two-device chain.
        for (i = 0; i < 7; i = i + 1) begin
            w = $random(seed);
            if (i == 0) w[15:0] = 16'hFFC0;
            if (i == 1) w[15:0] = 16'h0100;
            if (i == 2) w[15:0] = 16'h00FE;
            n = (i == 4) ? 32 : 16;
            i_host.send(w, n);
            chk(i_host.rx, (n == 32) ? {prev, w[31:16]} : {16'h0000, prev});
            {exp_r, exp_l} = w[15:0];
            prev = w[15:0];
            wt(8);
            chk(oe, 1'b0);
            check_out;
        end
        // Crossing wait: right gets two toggles, left waits for the timeout.
        zce <= 1'b1;
        w = {16'h0000, ~prev};
        i_host.send(w, 16);
        wt(8);
        check_out;
        rzc <= ~rzc;
        wt(8);
        check_out;
        rzc <= ~rzc;
        wt(8);
        exp_r = w[15:8];
        check_out;
        wt(200);
        exp_l = w[7:0];
        check_out;
        // Hardware mute waits for a crossing even with the wait disabled.
        zce <= 1'b0;
        mute_n_in <= 1'b0;
        wt(8);
        chk(hmute, 1'b0);
        lzc <= ~lzc;
        wt(8);
        chk(hmute, 1'b1);
        exp_l = 8'h00;
        exp_r = 8'h00;
        check_out;
        mute_n_in <= 1'b1;
        wt(8);
        chk(hmute, 1'b0);
        i_host.send(32'h0000_1234, 16);
        chk(i_host.rx, 32'h0000_0000);
        wt(8);
        {exp_r, exp_l} = 16'h1234;
        check_out;
        prev = 16'h1234;
        // Host ramps both codes down to software mute.
        for (i = 3; i >= 0; i = i - 1) begin
            w = {16'h0000, i[7:0], i[7:0]};
            i_host.send(w, 16);
            chk(i_host.rx, {16'h0000, prev});
            prev = w[15:0];
            wt(8);
            {exp_r, exp_l} = w[15:0];
            check_out;
        end
        conclude;
    end
endmodule
